// ---- wsg_cpu_end.sv ----
// processor end: machine cycles, phase clocks, strobe and ready sampling
`default_nettype none
// Overview of operation
// (R1) ready high ends access at phase-one fall
// (R2) ready low adds one cycle, bus held
// (R3) on-chip accesses ignore ready entirely
// (R4) access start pulses low in phase one low
// (R5) access start used only while phase one low
// (R6) access start plus decode gives one wait
// (R7) N waits per 100 ns above 40 ns
// (R8) ready stays high until sampled again
// (R9) first stage toggles on phase-two fall
// (R10) ready high until a slow select starts
// (R11) each extra wait adds a chained stage
// (R12) unused selects inactive, never start waits
// (R13) data lower half fast, upper half slow
// (R14) ready and enables from separate decoders
// (R15) address, select, direction, then strobe low
// (R16) after reset generator idle, ready high
module wsg_cpu_end (
  // link side
  wsg_link_if.dev_mp                       bus,
  // user side clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // access request
  input  wire logic                        req_valid,
  input  wire logic [wsg_pkg::ADDR_W-1:0]  req_addr,
  input  wire wsg_pkg::wsg_space_t         req_space,
  input  wire logic                        req_write,
  input  wire logic [wsg_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic                        req_internal,
  // access answer
  output logic                             req_ready,
  output logic                             resp_done,
  output logic [wsg_pkg::DATA_W-1:0]       resp_rdata
);
  // user-domain state; request fields hold still while busy, so the link
  // side may copy them once the request toggle has crossed
  typedef struct packed {
    logic                       busy;
    logic                       rdy;
    logic                       req_tog;
    logic                       ack1;
    logic                       ack2;
    logic                       ack_seen;
    logic                       done;
    logic [wsg_pkg::ADDR_W-1:0] addr;
    wsg_pkg::wsg_space_t        space;
    logic                       write;
    logic                       internal;
    logic [wsg_pkg::DATA_W-1:0] wdata;
    logic [wsg_pkg::DATA_W-1:0] rdata;
  } wsg_sys_st_t;

  // link-domain state; read data settles before the answer toggle flips
  typedef struct packed {
    logic                       rst1;
    logic                       rst2;
    logic                       tog1;
    logic                       tog2;
    logic                       tog_seen;
    logic                       ack_tog;
    logic [1:0]                 qtr;
    logic                       busy;
    logic                       fin;
    logic [wsg_pkg::ADDR_W-1:0] addr;
    wsg_pkg::wsg_space_t        space;
    logic                       write;
    logic                       internal;
    logic [wsg_pkg::DATA_W-1:0] wdata;
    logic [wsg_pkg::DATA_W-1:0] rdata;
    logic                       clk1;
    logic                       clk2;
    logic                       msc_n;
    logic                       bus_access_strobe_n_n;
    logic                       ps_n;
    logic                       ds_n;
    logic                       is_n;
    logic                       rw;
    logic                       doe_n;
  } wsg_lnk_st_t;

  wsg_sys_st_t s_q;
  wsg_sys_st_t s_d;
  wsg_lnk_st_t l_q;
  wsg_lnk_st_t l_d;
  logic        starting;
  logic        ext;

  // user domain: request capture and answer from the toggle handshake
  always_comb begin
    s_d      = s_q;
    s_d.ack1 = l_q.ack_tog;
    s_d.ack2 = s_q.ack1;
    s_d.done = 1'b0;
    if (s_q.ack2 != s_q.ack_seen) begin
      s_d.ack_seen = s_q.ack2;
      s_d.busy     = 1'b0;
      s_d.done     = 1'b1;
      s_d.rdata    = l_q.rdata;
    end
    if (req_valid && !s_q.busy) begin
      s_d.busy     = 1'b1;
      s_d.req_tog  = !s_q.req_tog;
      s_d.addr     = req_addr;
      s_d.space    = req_space;
      s_d.write    = req_write;
      s_d.internal = req_internal;
      s_d.wdata    = req_wdata;
    end
    if (!rst_n) begin
      s_d = '0;
    end
    // acceptance flag kept in a flop of its own for the port
    s_d.rdy = !s_d.busy;
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  // link domain: one machine cycle is four link clocks
  always_comb begin
    l_d      = l_q;
    l_d.rst1 = rst_n;
    l_d.rst2 = l_q.rst1;
    l_d.tog1 = s_q.req_tog;
    l_d.tog2 = l_q.tog1;
    l_d.qtr  = l_q.qtr + wsg_pkg::QTR_STEP;
    // a new access may only begin where the previous one ends
    starting = (l_q.qtr == wsg_pkg::QTR_3) && (!l_q.busy || l_q.fin)
               && (l_q.tog2 != l_q.tog_seen);
    // ready sampled at the end of the third quarter; low adds a cycle [R2]
    if ((l_q.qtr == wsg_pkg::QTR_2) && l_q.busy && !l_q.fin
        && (l_q.internal || bus.ready)) begin // [R1] [R3]
      l_d.fin = 1'b1;
      if (!l_q.internal && !l_q.write) begin
        l_d.rdata = bus.data_in;
      end
    end
    // access ends where phase one falls [R1]
    if ((l_q.qtr == wsg_pkg::QTR_3) && l_q.fin) begin
      l_d.busy    = 1'b0;
      l_d.fin     = 1'b0;
      l_d.ack_tog = !l_q.ack_tog;
    end
    if (starting) begin
      l_d.busy     = 1'b1;
      l_d.fin      = 1'b0;
      l_d.tog_seen = l_q.tog2;
      l_d.addr     = s_q.addr;
      l_d.space    = s_q.space;
      l_d.write    = s_q.write;
      l_d.internal = s_q.internal;
      l_d.wdata    = s_q.wdata;
    end
    ext       = l_d.busy && !l_d.internal;
    l_d.clk1  = !((l_d.qtr == wsg_pkg::QTR_0) || (l_d.qtr == wsg_pkg::QTR_1));
    l_d.clk2  = !((l_d.qtr == wsg_pkg::QTR_1) || (l_d.qtr == wsg_pkg::QTR_2));
    l_d.msc_n = !starting; // [R4]
    // selects and direction stand for the whole access, waits included [R15] [R2]
    l_d.ps_n   = !(ext && (l_d.space == wsg_pkg::WSG_SP_PROG)); // [R15]
    l_d.ds_n   = !(ext && (l_d.space == wsg_pkg::WSG_SP_DATA)); // [R15]
    l_d.is_n   = !(ext && (l_d.space == wsg_pkg::WSG_SP_IO)); // [R15]
    l_d.rw     = !(ext && l_d.write); // [R15]
    l_d.bus_access_strobe_n_n = !(ext && !l_d.fin && !starting); // [R15] [R2]
    l_d.doe_n  = !(ext && l_d.write && !l_d.fin && !starting);
    // reset reaches this side only through its own two flops
    if (!l_q.rst2) begin
      l_d.tog_seen = 1'b0;
      l_d.ack_tog  = 1'b0;
      l_d.qtr      = wsg_pkg::QTR_0;
      l_d.busy     = 1'b0;
      l_d.fin      = 1'b0;
      l_d.clk1     = 1'b1;
      l_d.clk2     = 1'b1;
      l_d.msc_n    = 1'b1;
      l_d.bus_access_strobe_n_n   = 1'b1;
      l_d.ps_n     = 1'b1;
      l_d.ds_n     = 1'b1;
      l_d.is_n     = 1'b1;
      l_d.rw       = 1'b1;
      l_d.doe_n    = 1'b1;
    end
  end

  always_ff @(posedge bus.link_clk) begin
    l_q <= l_d;
  end

  // every port below is a flop of one of the two state words
  assign req_ready                  = s_q.rdy;
  assign resp_done                  = s_q.done;
  assign resp_rdata                 = s_q.rdata;
  assign bus.addr                   = l_q.addr;
  assign bus.program_space_select_n = l_q.ps_n;
  assign bus.data_space_select_n    = l_q.ds_n;
  assign bus.io_space_select_n      = l_q.is_n;
  assign bus.bus_access_strobe_n    = l_q.bus_access_strobe_n_n;
  assign bus.rw                     = l_q.rw;
  assign bus.access_start_n         = l_q.msc_n;
  assign bus.phase_clock_one_out    = l_q.clk1;
  assign bus.phase_clock_two_out    = l_q.clk2;
  assign bus.data_out               = l_q.wdata;
  assign bus.data_oe_n              = l_q.doe_n;
endmodule : wsg_cpu_end
`default_nettype wire

// ---- wsg_pkg.sv ----
// shared constants and types for the wait-state bus link
`default_nettype none
package wsg_pkg;
  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  // wait-state configuration and counter widths
  localparam int WS_W  = 2;
  localparam int CNT_W = 3;
  // address bit that splits the data space into a fast and a slow half
  localparam int SLOW_ADDR_BIT = 15;
  // access-time steps that set how many wait states a target needs
  localparam int WS_BASE_NS = 40;
  localparam int WS_STEP_NS = 100;
  // quarters of one machine cycle, one link clock each
  localparam logic [1:0] QTR_0 = 2'h0;
  localparam logic [1:0] QTR_1 = 2'h1;
  localparam logic [1:0] QTR_2 = 2'h2;
  localparam logic [1:0] QTR_3 = 2'h3;
  localparam logic [1:0] QTR_STEP = 2'h1;
  // wait counter constants
  localparam logic [CNT_W-1:0] CNT_IDLE = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
  // memory chip select lanes
  localparam int CS_FAST = 0;
  localparam int CS_SLOW = 1;
  localparam logic [1:0] CS_NONE = 2'h3;
  // address spaces
  typedef enum logic [1:0] {
    WSG_SP_PROG,
    WSG_SP_DATA,
    WSG_SP_IO
  } wsg_space_t;
endpackage : wsg_pkg
`default_nettype wire

// ---- wsg_link_if.sv ----
// external bus between the processor end and the wait-state generator
`default_nettype none
interface wsg_link_if (
  input wire logic link_clk
);
  logic [wsg_pkg::ADDR_W-1:0] addr;
  logic                       program_space_select_n;
  logic                       data_space_select_n;
  logic                       io_space_select_n;
  logic                       bus_access_strobe_n;
  logic                       rw;
  logic                       access_start_n;
  logic                       phase_clock_one_out;
  logic                       phase_clock_two_out;
  logic                       ready;
  logic [wsg_pkg::DATA_W-1:0] data_out;
  logic                       data_oe_n;
  logic [wsg_pkg::DATA_W-1:0] data_in;

  modport dev_mp (
    input  link_clk, ready, data_in,
    output addr, program_space_select_n, data_space_select_n, io_space_select_n,
    output bus_access_strobe_n, rw, access_start_n,
    output phase_clock_one_out, phase_clock_two_out, data_out, data_oe_n
  );

  modport wsg_mp (
    input  link_clk, addr, program_space_select_n, data_space_select_n,
    input  io_space_select_n, bus_access_strobe_n, rw, access_start_n,
    input  phase_clock_one_out, phase_clock_two_out,
    output ready
  );
endinterface : wsg_link_if
`default_nettype wire

// ---- wsg_wait_gen.sv ----
// wait-state generator: ready sequencing and split chip enables
`default_nettype none
module wsg_wait_gen (
  // link side
  wsg_link_if.wsg_mp                      bus,
  // reset from the user domain
  input  wire logic                       rst_n,
  // wait states for the slow data half
  input  wire logic [wsg_pkg::WS_W-1:0]   ws_data_hi,
  // wait states for the i/o space
  input  wire logic [wsg_pkg::WS_W-1:0]   ws_io,
  // memory enables, fast and slow bank
  output logic [1:0]                      memory_chip_select_n,
  // wait sequence in progress
  output logic                            wait_active
);
  typedef struct packed {
    logic                       rst1;
    logic                       rst2;
    logic [wsg_pkg::WS_W-1:0]   wsd1;
    logic [wsg_pkg::WS_W-1:0]   wsd2;
    logic [wsg_pkg::WS_W-1:0]   wsi1;
    logic [wsg_pkg::WS_W-1:0]   wsi2;
    logic                       clk2_prev;
    logic [wsg_pkg::CNT_W-1:0]  cnt;
    logic                       ready;
    logic [1:0]                 cs_n;
    logic                       wait_act;
  } wsg_gen_st_t;

  wsg_gen_st_t              g_q;
  wsg_gen_st_t              g_d;
  logic                     clk2_fall;
  logic                     slow_half;
  logic                     fast_sel;
  logic                     slow_sel;
  logic [wsg_pkg::WS_W-1:0] slow_ws;
  logic                     start;

  always_comb begin
    g_d           = g_q;
    g_d.rst1      = rst_n;
    g_d.rst2      = g_q.rst1;
    g_d.wsd1      = ws_data_hi;
    g_d.wsd2      = g_q.wsd1;
    g_d.wsi1      = ws_io;
    g_d.wsi2      = g_q.wsi1;
    g_d.clk2_prev = bus.phase_clock_two_out;
    // stage clock: falling edge of phase two
    clk2_fall     = g_q.clk2_prev && !bus.phase_clock_two_out; // [R9]
    slow_half     = bus.addr[wsg_pkg::SLOW_ADDR_BIT];

    // ready decoder: wait count picked from space and address half
    slow_ws = '0;
    if (!bus.data_space_select_n && slow_half) begin // [R13]
      slow_ws = g_q.wsd2; // [R7]
    end else if (!bus.io_space_select_n) begin
      slow_ws = g_q.wsi2; // [R7]
    end

    // a zero count stands for an unused select: no sequence at all
    start = !bus.access_start_n && !bus.phase_clock_one_out
            && (slow_ws != '0); // [R5] [R6] [R12]

    // one count above the wait total: the first phase-two fall of the
    // access falls before ready is sampled and must not release it
    if (start) begin
      g_d.cnt = {{(wsg_pkg::CNT_W - wsg_pkg::WS_W){1'b0}}, slow_ws}
                + wsg_pkg::CNT_ONE; // [R10] [R11]
    end else if (clk2_fall && (g_q.cnt != wsg_pkg::CNT_IDLE)) begin
      g_d.cnt = g_q.cnt - wsg_pkg::CNT_ONE; // [R9] [R11]
    end

    // ready low while stages run, then high until the next start
    g_d.ready    = (g_d.cnt == wsg_pkg::CNT_IDLE); // [R8] [R10]
    g_d.wait_act = !g_d.ready;

    // enable decoder, independent of the ready path
    fast_sel = !bus.program_space_select_n
               || (!bus.data_space_select_n && !slow_half); // [R14] [R13]
    slow_sel = !bus.io_space_select_n
               || (!bus.data_space_select_n && slow_half); // [R14] [R13]
    g_d.cs_n[wsg_pkg::CS_FAST] = !(fast_sel && !bus.bus_access_strobe_n); // [R14]
    g_d.cs_n[wsg_pkg::CS_SLOW] = !(slow_sel && !bus.bus_access_strobe_n); // [R14]

    if (!g_q.rst2) begin
      g_d.clk2_prev = 1'b1;
      g_d.cnt       = wsg_pkg::CNT_IDLE; // [R16]
      g_d.ready     = 1'b1; // [R16]
      g_d.wait_act  = 1'b0;
      g_d.cs_n      = wsg_pkg::CS_NONE;
    end
  end

  always_ff @(posedge bus.link_clk) begin
    g_q <= g_d;
  end

  assign bus.ready            = g_q.ready;
  assign memory_chip_select_n = g_q.cs_n;
  assign wait_active          = g_q.wait_act;
endmodule : wsg_wait_gen
`default_nettype wire

// ---- wsg_link_properties.sv ----
// concurrent checks on the wait-state bus link
`default_nettype none
module wsg_link_properties (
  // link clock and reset
  input wire logic                       link_clk,
  input wire logic                       rst_n,
  // bus signals
  input wire logic [wsg_pkg::ADDR_W-1:0] addr,
  input wire logic                       program_space_select_n,
  input wire logic                       data_space_select_n,
  input wire logic                       io_space_select_n,
  input wire logic                       bus_access_strobe_n,
  input wire logic                       rw,
  input wire logic                       access_start_n,
  input wire logic                       phase_clock_one_out,
  input wire logic                       phase_clock_two_out,
  input wire logic                       ready,
  input wire logic                       data_oe_n
);
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  logic sel;
  logic smp;
  // one space select active, and the quarter where ready is sampled
  assign sel = !(program_space_select_n && data_space_select_n && io_space_select_n);
  assign smp = !bus_access_strobe_n && phase_clock_one_out && !phase_clock_two_out;
  a_start_phase_low: assert property (!access_start_n |-> !phase_clock_one_out)
    else $error("access start outside phase one low");
  a_start_one_qtr: assert property (!access_start_n |=> access_start_n)
    else $error("access start longer than one quarter");
  a_ready_ends: assert property (smp && ready |=> bus_access_strobe_n)
    else $error("access not ended after ready high");
  a_wait_holds: assert property (smp && !ready |=>
    (!bus_access_strobe_n && $stable(addr) && sel)[*4])
    else $error("bus not held during wait cycle");
  a_strobe_after_sel: assert property ($fell(bus_access_strobe_n) |->
    sel && $past(sel) && !$past(access_start_n))
    else $error("strobe low without prior select");
  a_write_dir: assert property (!data_oe_n |-> !rw)
    else $error("data driven while direction is read");
  a_ready_held: assert property ($rose(ready) |-> ready[*3])
    else $error("ready dropped before next sample");
  a_ready_drop_start: assert property ($fell(ready) |->
    !$past(access_start_n) && $past(sel))
    else $error("ready low without a selected start");
  a_idle_reset: assert property (disable iff (1'b0) !rst_n[*5] |->
    ready && bus_access_strobe_n && access_start_n)
    else $error("link not idle in reset");
  c_wait: cover property (smp && !ready);
  c_zero_wait: cover property (smp && ready);
  c_write: cover property (!data_oe_n);
endmodule : wsg_link_properties
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the processor end and wait-state generator
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [15:0] d; logic [1:0] k; int w [4];} wsg_exp_t;
  logic                clk_sys = 1'b0;
  logic                link_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                req_valid = 1'b0;
  logic                req_write = 1'b0;
  logic                req_internal = 1'b0;
  logic [15:0]         req_addr = 16'h0000;
  logic [15:0]         req_wdata = 16'h0000;
  wsg_pkg::wsg_space_t req_space = wsg_pkg::WSG_SP_PROG;
  logic [1:0]          ws_data_hi = 2'h0;
  logic [1:0]          ws_io = 2'h0;
  logic                req_ready;
  logic                resp_done;
  logic [15:0]         resp_rdata;
  logic [1:0]          mem_cs_n;
  logic                wait_active;
  logic [15:0]         noise = 16'h0000;
  logic [15:0]         wseen = 16'h0000;
  logic [15:0]         lfsr = 16'h0041;
  int                  n_errors = 0;
  int                  checked = 0;
  int                  issued = 0;
  int                  done = 0;
  int                  tally [4] = '{default: 0};
  int                  base [4] = '{default: 0};
  logic                hung = 1'b0;
  wsg_exp_t            q[$];
  wsg_exp_t            e;
  always #2 clk_sys = ~clk_sys;
  initial #1.3 forever #40 link_clk = ~link_clk;
  wsg_link_if u_wsg_link_if (.link_clk(link_clk));
  wsg_cpu_end u_wsg_cpu_end (.bus(u_wsg_link_if.dev_mp), .clk_sys(clk_sys), .rst_n(rst_n),
    .req_valid(req_valid), .req_addr(req_addr), .req_space(req_space), .req_write(req_write),
    .req_wdata(req_wdata), .req_internal(req_internal), .req_ready(req_ready),
    .resp_done(resp_done), .resp_rdata(resp_rdata));
  wsg_wait_gen u_wsg_wait_gen (.bus(u_wsg_link_if.wsg_mp), .rst_n(rst_n),
    .ws_data_hi(ws_data_hi), .ws_io(ws_io), .memory_chip_select_n(mem_cs_n),
    .wait_active(wait_active));
  wsg_link_properties u_wsg_link_properties (.link_clk(link_clk), .rst_n(rst_n),
    .addr(u_wsg_link_if.addr), .program_space_select_n(u_wsg_link_if.program_space_select_n),
    .data_space_select_n(u_wsg_link_if.data_space_select_n),
    .io_space_select_n(u_wsg_link_if.io_space_select_n),
    .bus_access_strobe_n(u_wsg_link_if.bus_access_strobe_n), .rw(u_wsg_link_if.rw),
    .access_start_n(u_wsg_link_if.access_start_n),
    .phase_clock_one_out(u_wsg_link_if.phase_clock_one_out),
    .phase_clock_two_out(u_wsg_link_if.phase_clock_two_out), .ready(u_wsg_link_if.ready),
    .data_oe_n(u_wsg_link_if.data_oe_n));
  // memory model: answers reads, shows a changing pattern when the bus is released
  assign u_wsg_link_if.data_in = !u_wsg_link_if.data_oe_n ? u_wsg_link_if.data_out :
    (!u_wsg_link_if.bus_access_strobe_n && u_wsg_link_if.rw) ?
    u_wsg_link_if.addr ^ 16'hA5C3 : noise;
  always @(posedge link_clk) noise <= noise + 16'h3B5D;
  // quarters of strobe, each bank enable and wait active; last write word seen
  always @(negedge link_clk) begin
    if (u_wsg_link_if.bus_access_strobe_n === 1'b0) begin
      tally[0] <= tally[0] + 1;
      if (u_wsg_link_if.rw === 1'b0) wseen <= u_wsg_link_if.data_out;
    end
    if (mem_cs_n[wsg_pkg::CS_FAST] === 1'b0) tally[1] <= tally[1] + 1;
    if (mem_cs_n[wsg_pkg::CS_SLOW] === 1'b0) tally[2] <= tally[2] + 1;
    if (wait_active === 1'b1) tally[3] <= tally[3] + 1;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_width(input int got, input int exp);
    checked++;
    if (got != exp) begin
      n_errors++;
      $display("mismatch %0t quarter count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_width
  task automatic close_out;
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  always @(negedge clk_sys) begin
    if (resp_done === 1'b1) begin
      done++;
      if (q.size() == 0) chk_width(-1, 0);
      else begin
        e = q.pop_front();
        if (e.k == 2'h0) chk_data(resp_rdata, e.d);
        if (e.k == 2'h1) chk_data(wseen, e.d);
        for (int j = 0; j < 4; j++) begin
          chk_width(tally[j] - base[j], e.w[j]);
          base[j] = tally[j];
        end
      end
    end
  end
  // one access; waits counts the expected wait states
  task automatic access(input wsg_pkg::wsg_space_t sp, input logic [15:0] a,
                        input logic inl, input int waits);
    int       n;
    logic     slow;
    wsg_exp_t x;
    if (hung) return;
    slow = (sp == wsg_pkg::WSG_SP_IO)
           || ((sp == wsg_pkg::WSG_SP_DATA) && a[wsg_pkg::SLOW_ADDR_BIT]);
    @(negedge clk_sys);
    lfsr = nxt(lfsr);
    req_valid = 1'b1;
    req_space = sp;
    req_addr = a;
    req_write = lfsr[3];
    req_internal = inl;
    req_wdata = lfsr;
    x.k = inl ? 2'h2 : {1'b0, lfsr[3]};
    x.d = lfsr[3] ? lfsr : a ^ 16'hA5C3;
    x.w[0] = inl ? 0 : 2 + 4 * waits;
    x.w[1] = slow ? 0 : x.w[0];
    x.w[2] = slow ? x.w[0] : 0;
    x.w[3] = (inl || waits == 0) ? 0 : 1 + 4 * waits;
    q.push_back(x);
    issued++;
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (done != issued && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (done != issued) begin
      n_errors++;
      hung = 1'b1;
    end
  endtask : access
  initial begin
    repeat (6) @(posedge link_clk);
    @(negedge clk_sys) rst_n = 1'b1;
    repeat (4) @(posedge link_clk);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      ws_data_hi = 2'(i);
      ws_io = 2'(3 - i);
      repeat (3) @(posedge link_clk);
      lfsr = nxt(lfsr);
      access(wsg_pkg::WSG_SP_DATA, {1'b1, lfsr[14:0]}, 1'b0, i % 4);
      access(wsg_pkg::WSG_SP_IO, lfsr, 1'b0, 3 - (i % 4));
      access(wsg_pkg::WSG_SP_PROG, ~lfsr, 1'b0, 0);
      access(wsg_pkg::WSG_SP_DATA, {1'b0, lfsr[15:1]}, 1'b0, 0);
      access(wsg_pkg::WSG_SP_DATA, {1'b1, lfsr[15:1]}, 1'b1, 0);
    end
    close_out();
  end
endmodule : testbench
`default_nettype wire
